/* src/iopf_pkg.sv */
// Purpose: Shared constants for the I/O pin function configuration block.
// Assumes: Pointer byte splits into a mode nibble and a selector nibble.
// Notes: Function indices address the pin function array inside the block.
package iopf_pkg;
	// Pointer byte mode nibbles.
	localparam logic [3:0] MODE_CONFIG = 4'h0;
	localparam logic [3:0] MODE_DAC_WR = 4'h1;
	// Control register selectors.
	localparam logic [3:0] SEL_GEN_CTRL = 4'h3;
	localparam logic [3:0] SEL_ADC_PINS = 4'h4;
	localparam logic [3:0] SEL_DAC_PINS = 4'h5;
	localparam logic [3:0] SEL_PULLDOWN = 4'h6;
	localparam logic [3:0] SEL_LOAD_DAC = 4'h7;
	localparam logic [3:0] SEL_GPO_PINS = 4'h8;
	localparam logic [3:0] SEL_GPO_DATA = 4'h9;
	localparam logic [3:0] SEL_GPI_PINS = 4'ha;
	localparam logic [3:0] SEL_OPEN_DRN = 4'hc;
	localparam logic [3:0] SEL_TRISTATE = 4'hd;
	// General control field positions.
	localparam int GC_PRECHARGE = 9;
	localparam int GC_BUF_EN = 8;
	localparam int GC_LOCK = 7;
	localparam int GC_BROADCAST = 6;
	localparam int GC_ADC_RANGE = 5;
	localparam int GC_DAC_RANGE = 4;
	// Reset values.
	localparam logic [15:0] GC_RESET = 16'h0000;
	localparam logic [7:0] FN_RESET = 8'h00;
	localparam logic [7:0] PD_RESET = 8'hff;
	localparam logic [1:0] LOAD_DAC_CONTROL_RESET = 2'h0;
	// Load-DAC transfer modes.
	localparam logic [1:0] LOAD_DAC_CONTROL_IMMEDIATE = 2'h0;
	localparam logic [1:0] LOAD_DAC_CONTROL_HOLD = 2'h1;
	localparam logic [1:0] LOAD_DAC_CONTROL_TRANSFER = 2'h2;
	// Pin function indices; the two pairs below may coexist on one pin.
	localparam logic [2:0] FN_ADC = 3'h0;
	localparam logic [2:0] FN_DAC = 3'h1;
	localparam logic [2:0] FN_PD = 3'h2;
	localparam logic [2:0] FN_GPO = 3'h3;
	localparam logic [2:0] FN_GPI = 3'h4;
	localparam logic [2:0] FN_TRI = 3'h5;
	localparam logic [2:0] FN_NONE = 3'h7;
	localparam int FN_COUNT = 6;
	// Serial link byte framing.
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_ACK_END = 4'h9;
	// Serial protocol states.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_PTR = 3'b010,
		ST_MSB = 3'b011,
		ST_LSB = 3'b100,
		ST_DONE = 3'b101
	} iopf_state_t;
endpackage : iopf_pkg

/* src/iopf_top.sv */
// Purpose: Serial write path, control register and pin function selection.
// Assumes: scl and sda arrive unsynchronised; conv_active is on clk.
// Notes: Readback is not served; reads are not acknowledged.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Precharge off keeps enabled buffer powered.
// - Precharge on powers buffer only during conversion.
// - Buffer enable bit gates buffer, default off.
// - Lock bit discards pin function register writes.
// - Broadcast bit loads all DAC-configured channels.
// - ADC range bit drives ADC span.
// - DAC range bit drives DAC span.
// - Mode nibble zero selects control register.
// - All pins pull down after reset.
// - Bit n of function register is pin n.
// - Latest function write wins on conflicts.
// - DAC and ADC may share a pin.
// - Digital input reports sampled state of input pin.
// - Three-state and open-drain or push-pull outputs.
// - Mode nibble one writes selected DAC input.
// - Input to DAC copy follows load mode.
// - Load modes immediate, hold, transfer-then-hold.
// - Selector five is the DAC pin register.
module iopf_top
	import iopf_pkg::*;
#(
	parameter logic [6:0] I2C_ADDR = 7'h10,
	parameter int DAC_BITS = 12
)(
	input wire logic clk,
	input wire logic rstn,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic conv_active,
	input wire logic [7:0] io_pin_in,
	output logic [7:0] io_pin_out,
	output logic [7:0] io_pin_oe_n,
	output logic [7:0] adc_pins,
	output logic [7:0] dac_pins,
	output logic [7:0] pulldown_pins,
	output logic [7:0] tristate_pins,
	output logic [7:0] gpio_in_state,
	output logic adc_buf_power,
	output logic adc_range_2x,
	output logic dac_range_2x,
	output logic [1:0] load_dac_control,
	output logic [8*DAC_BITS-1:0] dac_value
);
	// Elaboration guard: the data bytes carry at most twelve DAC bits.
	generate
		if (DAC_BITS < 1 || DAC_BITS > 12)
		begin : g_bad_width
			$error("DAC_BITS must lie between 1 and 12");
		end
	endgenerate

	// Maps a selector to a pin function index, or FN_NONE.
	function automatic logic [2:0] sel_to_fn(input logic [3:0] sel);
		case (sel)
			SEL_ADC_PINS: sel_to_fn = FN_ADC;
			SEL_DAC_PINS: sel_to_fn = FN_DAC;
			SEL_PULLDOWN: sel_to_fn = FN_PD;
			SEL_GPO_PINS: sel_to_fn = FN_GPO;
			SEL_GPI_PINS: sel_to_fn = FN_GPI;
			SEL_TRISTATE: sel_to_fn = FN_TRI;
			default: sel_to_fn = FN_NONE;
		endcase
	endfunction : sel_to_fn

	// Returns the function that may coexist with the given one.
	function automatic logic [2:0] fn_partner(input logic [2:0] fn);
		case (fn)
			FN_ADC: fn_partner = FN_DAC;
			FN_DAC: fn_partner = FN_ADC;
			FN_GPO: fn_partner = FN_GPI;
			FN_GPI: fn_partner = FN_GPO;
			default: fn_partner = FN_NONE;
		endcase
	endfunction : fn_partner

	logic scl_s1_r, scl_s2_r, scl_d_r;
	logic sda_s1_r, sda_s2_r, sda_d_r;
	logic [7:0] pin_s1_r, pin_s2_r;
	logic scl_rise, scl_fall, start_det, stop_det;
	iopf_state_t state_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r, ptr_r, msb_r;
	logic ack_r;
	logic byte_done;
	logic wr_stb_r;
	logic [15:0] wr_data_r;
	logic [15:0] gc_r;
	logic [7:0] fn_r [FN_COUNT];
	logic [7:0] open_drain_r, gpo_data_r;
	logic [1:0] load_dac_control_r;
	logic [DAC_BITS-1:0] in_reg_r [8];
	logic [DAC_BITS-1:0] dac_reg_r [8];
	logic cfg_wr, dac_wr, locked;
	logic [2:0] wr_fn;

	// Two-stage synchronisers; only the second stage feeds edge logic.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r <= 1'b1;
			pin_s1_r <= 8'h00;
			pin_s2_r <= 8'h00;
		end
		else
		begin
			scl_s1_r <= scl_in;
			scl_s2_r <= scl_s1_r;
			scl_d_r <= scl_s2_r;
			sda_s1_r <= sda_in;
			sda_s2_r <= sda_s1_r;
			sda_d_r <= sda_s2_r;
			pin_s1_r <= io_pin_in;
			pin_s2_r <= pin_s1_r;
		end
	end

	// Bus events seen on the synchronised lines.
	assign scl_rise = scl_s2_r && !scl_d_r;
	assign scl_fall = !scl_s2_r && scl_d_r;
	assign start_det = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
	assign stop_det = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;
	assign byte_done = scl_fall && (bit_cnt_r == BIT_ACK);

	// Byte framing: eight data bits, then an acknowledge slot we drive low.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= ST_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			ack_r <= 1'b0;
		end
		else if (start_det)
		begin
			state_r <= ST_ADDR;
			bit_cnt_r <= 4'h0;
			ack_r <= 1'b0;
		end
		else if (stop_det)
		begin
			state_r <= ST_IDLE;
			ack_r <= 1'b0;
		end
		else if (state_r != ST_IDLE && state_r != ST_DONE)
		begin
			if (scl_rise && bit_cnt_r < BIT_ACK)
			begin
				shift_r <= {shift_r[6:0], sda_s2_r};
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end
			else if (byte_done)
			begin
				// Reads are refused so the master sees a missing acknowledge.
				if (state_r != ST_ADDR || shift_r == {I2C_ADDR, 1'b0})
				begin
					ack_r <= 1'b1;
					bit_cnt_r <= BIT_ACK_END;
				end
				else
				begin
					state_r <= ST_IDLE;
				end
			end
			else if (scl_fall && bit_cnt_r == BIT_ACK_END)
			begin
				ack_r <= 1'b0;
				bit_cnt_r <= 4'h0;
				case (state_r)
					ST_ADDR: state_r <= ST_PTR;
					ST_PTR: state_r <= ST_MSB;
					ST_MSB: state_r <= ST_LSB;
					default: state_r <= ST_DONE;
				endcase
			end
		end
	end

	// Open-drain data line: we only ever pull low during acknowledge.
	assign sda_out = 1'b0;
	assign sda_oe_n = !ack_r;

	// Captures pointer and data bytes; the write is issued after the last byte.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ptr_r <= 8'h00;
			msb_r <= 8'h00;
			wr_stb_r <= 1'b0;
			wr_data_r <= 16'h0000;
		end
		else
		begin
			wr_stb_r <= byte_done && state_r == ST_LSB && !start_det && !stop_det;
			if (byte_done && state_r == ST_PTR)
			begin
				ptr_r <= shift_r;
			end
			if (byte_done && state_r == ST_MSB)
			begin
				msb_r <= shift_r;
			end
			if (byte_done && state_r == ST_LSB)
			begin
				wr_data_r <= {msb_r, shift_r};
			end
		end
	end

	assign cfg_wr = wr_stb_r && ptr_r[7:4] == MODE_CONFIG;
	assign dac_wr = wr_stb_r && ptr_r[7:4] == MODE_DAC_WR;
	assign locked = gc_r[GC_LOCK];
	assign wr_fn = sel_to_fn(ptr_r[3:0]);

	// Control, output data and load-mode registers.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			gc_r <= GC_RESET;
			open_drain_r <= FN_RESET;
			gpo_data_r <= FN_RESET;
			load_dac_control_r <= LOAD_DAC_CONTROL_RESET;
		end
		else if (cfg_wr)
		begin
			case (ptr_r[3:0])
				SEL_GEN_CTRL: gc_r <= wr_data_r;
				// drive style selection, locked like pin functions
				SEL_OPEN_DRN: open_drain_r <= locked ? open_drain_r : wr_data_r[7:0];
				SEL_GPO_DATA: gpo_data_r <= wr_data_r[7:0];
				SEL_LOAD_DAC:
				begin
					case (wr_data_r[1:0])
						LOAD_DAC_CONTROL_IMMEDIATE: load_dac_control_r <= LOAD_DAC_CONTROL_IMMEDIATE;
						LOAD_DAC_CONTROL_HOLD: load_dac_control_r <= LOAD_DAC_CONTROL_HOLD;
						LOAD_DAC_CONTROL_TRANSFER: load_dac_control_r <= LOAD_DAC_CONTROL_HOLD;
						default: load_dac_control_r <= load_dac_control_r;
					endcase
				end
				default: load_dac_control_r <= load_dac_control_r;
			endcase
		end
	end

	// Pin functions: the written register takes the data, and every other
	// function except the permitted partner loses those pins.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int f = 0; f < FN_COUNT; f++)
			begin
				fn_r[f] <= (3'(f) == FN_PD) ? PD_RESET : FN_RESET;
			end
		end
		else if (cfg_wr && !locked && wr_fn != FN_NONE)
		begin
			for (int f = 0; f < FN_COUNT; f++)
			begin
				if (3'(f) == wr_fn)
				begin
					fn_r[f] <= wr_data_r[7:0];
				end
				else if (3'(f) != fn_partner(wr_fn))
				begin
					fn_r[f] <= fn_r[f] & ~wr_data_r[7:0];
				end
			end
		end
	end

	// DAC input and output registers.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int c = 0; c < 8; c++)
			begin
				in_reg_r[c] <= '0;
				dac_reg_r[c] <= '0;
			end
		end
		else
		begin
			for (int c = 0; c < 8; c++)
			begin
				if (dac_wr && (gc_r[GC_BROADCAST] ? fn_r[FN_DAC][c] : ptr_r[2:0] == 3'(c)))
				begin
					in_reg_r[c] <= wr_data_r[DAC_BITS-1:0];
					if (load_dac_control_r == LOAD_DAC_CONTROL_IMMEDIATE)
					begin
						dac_reg_r[c] <= wr_data_r[DAC_BITS-1:0];
					end
				end
				else if (cfg_wr && ptr_r[3:0] == SEL_LOAD_DAC && wr_data_r[1:0] == LOAD_DAC_CONTROL_TRANSFER)
				begin
					dac_reg_r[c] <= in_reg_r[c];
				end
			end
		end
	end

	// Analog settings and pin drive, all registered.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			adc_buf_power <= 1'b0;
			adc_range_2x <= 1'b0;
			dac_range_2x <= 1'b0;
			io_pin_out <= 8'h00;
			io_pin_oe_n <= 8'hff;
			gpio_in_state <= 8'h00;
		end
		else
		begin
			adc_buf_power <= gc_r[GC_BUF_EN] && (!gc_r[GC_PRECHARGE] || conv_active);
			adc_range_2x <= gc_r[GC_ADC_RANGE];
			dac_range_2x <= gc_r[GC_DAC_RANGE];
			io_pin_out <= gpo_data_r & ~open_drain_r;
			io_pin_oe_n <= ~(fn_r[FN_GPO] & ~fn_r[FN_TRI] & ~(open_drain_r & gpo_data_r));
			gpio_in_state <= pin_s2_r & fn_r[FN_GPI];
		end
	end

	// Flatten DAC registers; pin maps come straight from registers.
	generate
		for (genvar g = 0; g < 8; g++)
		begin : g_dac_out
			assign dac_value[g*DAC_BITS +: DAC_BITS] = dac_reg_r[g];
		end
	endgenerate
	assign adc_pins = fn_r[FN_ADC];
	assign dac_pins = fn_r[FN_DAC];
	assign pulldown_pins = fn_r[FN_PD];
	assign tristate_pins = fn_r[FN_TRI];
	assign load_dac_control = load_dac_control_r;

	// Checks beside the logic they guard.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_lock_discard: assert property (cfg_wr && locked && wr_fn != FN_NONE |=>
		$stable(adc_pins) && $stable(dac_pins) && $stable(pulldown_pins) && $stable(tristate_pins))
		else $error("pin function changed while locked");
	a_buf_off: assert property (!gc_r[GC_BUF_EN] |=> !adc_buf_power)
		else $error("buffer powered while disabled");
	a_buf_always: assert property (gc_r[GC_BUF_EN] && !gc_r[GC_PRECHARGE] |=> adc_buf_power)
		else $error("buffer not powered without precharge");
	a_buf_precharge: assert property (gc_r[GC_BUF_EN] && gc_r[GC_PRECHARGE]
		|=> adc_buf_power == $past(conv_active))
		else $error("precharge buffer power wrong");
	a_range_write: assert property (cfg_wr && ptr_r[3:0] == SEL_GEN_CTRL
		|=> ##1 adc_range_2x == $past(wr_data_r[GC_ADC_RANGE], 2))
		else $error("adc range not applied");
	a_dac_pins: assert property (cfg_wr && !locked && ptr_r[3:0] == SEL_DAC_PINS
		|=> dac_pins == $past(wr_data_r[7:0]) && adc_pins == $past(adc_pins))
		else $error("dac pin register write wrong");
	a_fn_exclude: assert property (cfg_wr && !locked && ptr_r[3:0] == SEL_TRISTATE
		|=> (pulldown_pins & tristate_pins) == 8'h00 && (dac_pins & tristate_pins) == 8'h00)
		else $error("conflicting functions survive");
	a_dac_single: assert property (dac_wr && !gc_r[GC_BROADCAST] && load_dac_control_r == LOAD_DAC_CONTROL_IMMEDIATE
		|=> dac_reg_r[$past(ptr_r[2:0])] == $past(wr_data_r[DAC_BITS-1:0]))
		else $error("dac write not loaded");
	a_load_dac_control_hold: assert property (dac_wr && load_dac_control_r == LOAD_DAC_CONTROL_HOLD |=> $stable(dac_value))
		else $error("dac updated in hold mode");
	a_load_dac_control_revert: assert property (cfg_wr && ptr_r[3:0] == SEL_LOAD_DAC
		&& wr_data_r[1:0] == LOAD_DAC_CONTROL_TRANSFER |=> load_dac_control == LOAD_DAC_CONTROL_HOLD)
		else $error("load mode did not revert");
	a_ctrl_locked: assert property (cfg_wr && locked && ptr_r[3:0] == SEL_GEN_CTRL
		|=> gc_r == $past(wr_data_r))
		else $error("control write refused while locked");

	c_lock_write: cover property (cfg_wr && locked && wr_fn != FN_NONE);
	c_broadcast: cover property (dac_wr && gc_r[GC_BROADCAST]);
	c_transfer: cover property (cfg_wr && ptr_r[3:0] == SEL_LOAD_DAC && wr_data_r[1:0] == LOAD_DAC_CONTROL_TRANSFER);
	c_addr_ack: cover property (state_r == ST_ADDR && ack_r);
endmodule : iopf_top

`default_nettype wire

/* dv/iopf_i2c_host.sv */
// Purpose: Serial bus master model that writes frames into the block.
// Assumes: SDA has a pull-up; nobody drives it high.
// Notes: SCL stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module iopf_i2c_host #(
	parameter int H = 20
)(
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_low
);
	// Both lines start released, as an idle bus.
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Changes land 1 ns after an edge so no race with the sampler.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// SDA only moves in mid SCL low, so no false start or stop is seen.
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			tick(H / 2);
			sda_low = ~b[i];
			tick(H / 2);
			scl = 1'b1;
			tick(H);
			scl = 1'b0;
		end
		tick(H / 2);
		sda_low = 1'b0;
		tick(H / 2);
		scl = 1'b1;
		tick(H / 2);
		ack = ~sda_line;
		tick(H / 2);
		scl = 1'b0;
	endtask : put_byte
	// Start, address with write bit, pointer, two data bytes, stop.
	task automatic frame(input logic [6:0] adr, input logic [7:0] ptr,
		input logic [15:0] data, output logic [3:0] acks);
		sda_low = 1'b1;
		tick(H);
		scl = 1'b0;
		put_byte({adr, 1'b0}, acks[3]);
		put_byte(ptr, acks[2]);
		put_byte(data[15:8], acks[1]);
		put_byte(data[7:0], acks[0]);
		tick(H / 2);
		sda_low = 1'b1;
		tick(H / 2);
		scl = 1'b1;
		tick(H);
		sda_low = 1'b0;
		tick(H);
	endtask : frame
endmodule : iopf_i2c_host
`default_nettype wire

/* dv/test_io_pin_function_config.sv */
// Purpose: Self-checking bench for the pin function configuration block.
// Assumes: Effects settle well before a frame's stop condition ends.
// Notes: Reserved control bits are always written as zero.
`timescale 1ns/1ps
`default_nettype none
module test_io_pin_function_config;
	import iopf_pkg::*;
	localparam logic [6:0] DEV_ADDR = 7'h10;
	logic clk = 1'b0;
	logic rstn, conv_active, scl, sda_low, sda_out, sda_oe_n;
	logic adc_buf_power, adc_range_2x, dac_range_2x;
	logic [7:0] io_pin_in, io_pin_out, io_pin_oe_n, adc_pins, dac_pins;
	logic [7:0] pulldown_pins, tristate_pins, gpio_in_state;
	logic [1:0] load_dac_control;
	logic [95:0] dac_value;
	logic [3:0] acks;
	wire logic sda_line;
	int n_mismatch = 0;
	int checks_done = 0;
	// Open-drain wire with pull-up: low if either party pulls.
	assign sda_line = ~sda_low & (sda_oe_n | sda_out);
	// Free-running 250 MHz clock.
	always #2 clk = ~clk;
	iopf_top #(.I2C_ADDR(DEV_ADDR), .DAC_BITS(12)) iopf_top_i (.clk, .rstn,
		.scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe_n, .conv_active,
		.io_pin_in, .io_pin_out, .io_pin_oe_n, .adc_pins, .dac_pins,
		.pulldown_pins, .tristate_pins, .gpio_in_state, .adc_buf_power,
		.adc_range_2x, .dac_range_2x, .load_dac_control, .dac_value);
	iopf_i2c_host iopf_i2c_host_i (.clk, .sda_line, .scl, .sda_low);
	task automatic chk(input string what, input logic [95:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk
	// Every frame here should be acknowledged on all four bytes.
	task automatic wr(input logic [7:0] ptr, input logic [15:0] data);
		iopf_i2c_host_i.frame(DEV_ADDR, ptr, data, acks);
		chk("ack", acks, 4'hf);
	endtask : wr
	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	// Cuts a hang short; about two and a half times the expected run.
	initial
	begin
		#400000;
		chk("watchdog", 1'b1, 1'b0);
		close_out();
	end
	// Conversions stay off during reconfiguration except in the buffer test.
	initial
	begin
		rstn = 1'b0;
		conv_active = 1'b0;
		io_pin_in = 8'h00;
		repeat (20) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk("pulldown", pulldown_pins, PD_RESET);
		chk("masks", {adc_pins, dac_pins, tristate_pins}, 24'h0);
		chk("buffer", adc_buf_power, 1'b0);
		chk("pin oe_n", io_pin_oe_n, 8'hff);
		$display("test reset done");
		wr(8'h03, 16'h0120);
		chk("ranges", {adc_range_2x, dac_range_2x}, 2'b10);
		chk("buffer on", adc_buf_power, 1'b1);
		wr(8'h03, 16'h0310);
		chk("buffer idle", adc_buf_power, 1'b0);
		chk("ranges", {adc_range_2x, dac_range_2x}, 2'b01);
		conv_active = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("buffer conv", adc_buf_power, 1'b1);
		conv_active = 1'b0;
		wr(8'h03, 16'h0000);
		$display("test control done");
		wr(8'h05, 16'h0082);
		chk("dac pins", dac_pins, 8'h82);
		chk("pulldown", pulldown_pins, 8'h7d);
		wr(8'h04, 16'h0003);
		chk("adc dac pd", {adc_pins, dac_pins, pulldown_pins}, 24'h03827c);
		$display("test pins done");
		wr(8'h11, 16'h0abc);
		chk("dac1", dac_value[23:12], 12'habc);
		wr(8'h07, 16'h0001);
		wr(8'h17, 16'h0555);
		chk("dac7 held", dac_value[95:84], 12'h000);
		wr(8'h07, 16'h0002);
		chk("dac7", dac_value[95:84], 12'h555);
		chk("load mode", load_dac_control, LOAD_DAC_CONTROL_HOLD);
		wr(8'h07, 16'h0000);
		wr(8'h03, 16'h0040);
		wr(8'h10, 16'h0123);
		chk("broadcast", {dac_value[95:84], dac_value[23:0]}, 36'h123123000);
		wr(8'h03, 16'h0000);
		$display("test dac done");
		wr(8'h08, 16'h0010);
		wr(8'h09, 16'h0010);
		wr(8'h0a, 16'h0010);
		io_pin_in = 8'h30;
		repeat (4) @(posedge clk);
		#1;
		chk("gpio", {io_pin_out, io_pin_oe_n, gpio_in_state}, 24'h10ef10);
		wr(8'h0c, 16'h0010);
		chk("open drain", {io_pin_out, io_pin_oe_n}, 16'h00ff);
		wr(8'h0d, 16'h0020);
		chk("tristate", tristate_pins, 8'h20);
		$display("test gpio done");
		wr(8'h03, 16'h0080);
		wr(8'h05, 16'h00ff);
		chk("locked", dac_pins, 8'h82);
		wr(8'h03, 16'h0000);
		wr(8'h05, 16'h0001);
		chk("unlocked", dac_pins, 8'h01);
		iopf_i2c_host_i.frame(7'h11, 8'h05, 16'h00ff, acks);
		chk("foreign addr", {acks, dac_pins}, 12'h001);
		wr(8'h45, 16'h00ff);
		chk("other mode", dac_pins, 8'h01);
		wr(8'h06, 16'h0001);
		chk("pulldown back", {dac_pins, pulldown_pins}, 16'h0001);
		$display("test lock done");
		close_out();
	end
endmodule : test_io_pin_function_config
`default_nettype wire
